// File: core/dbg_port.sv
// Debug port: probe-facing test access port, core run/halt/step control,
// two compare units, monitor-mode data channel and flash readout lock.
// Assumes probe pins are asynchronous and much slower than sys_clk_i;
// core and flash interfaces are on sys_clk_i.
//
// How it works
// - Breakpoint, watchpoint or probe halt request stops the core.
// - Stopped core is held and isolated; probe still reaches state.
// - Probe can issue run, halt and single-step commands.
// - Two compare units, each a watchpoint or a breakpoint.
// - Breakpoint match may also require the fetched data value.
// - Monitor mode: a match raises an exception, core keeps running.
// - Monitor mode: probe and core exchange words without stopping code.
// - While locked, every probe flash read is refused.
// - Only the full erase command clears the lock, and blanks flash.
// - CPU reads the lock bit; it has no way to write it.
`timescale 1ns/1ps
module dbg_port (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        tck_i,
	input  wire logic        tms_i,
	input  wire logic        tdi_i,
	output logic             tdo_o,
	output logic             tdo_oe_n_o,
	input  wire logic        fetch_valid_i,
	input  wire logic [31:0] fetch_addr_i,
	input  wire logic [31:0] fetch_instr_i,
	input  wire logic        data_valid_i,
	input  wire logic [31:0] data_addr_i,
	input  wire logic [31:0] data_value_i,
	input  wire logic        instr_retire_i,
	output logic             core_halt_o,
	output logic             core_isolate_o,
	output logic             debug_exc_o,
	output logic [31:0]      comm_rx_data_o,
	output logic             comm_rx_valid_o,
	input  wire logic        comm_rx_ack_i,
	input  wire logic        comm_tx_valid_i,
	input  wire logic [31:0] comm_tx_data_i,
	output logic             comm_tx_full_o,
	output logic             flash_rd_req_o,
	output logic [31:0]      flash_rd_addr_o,
	input  wire logic        flash_rd_done_i,
	input  wire logic [31:0] flash_rd_data_i,
	output logic             flash_erase_req_o,
	input  wire logic        flash_erase_done_i,
	input  wire logic        lock_nv_i,
	input  wire logic        lock_program_i,
	output logic             cpu_lock_o
);
	// Pin synchronisers; the first stage feeds only the second
	logic [2:0] tck_sync_reg;
	logic [1:0] tms_sync_reg;
	logic [1:0] tdi_sync_reg;
	logic       tck_rise;
	logic       tck_fall;
	logic       tms_s;
	logic       tdi_s;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tck_sync_reg <= 3'h0;
			tms_sync_reg <= 2'h3;
			tdi_sync_reg <= 2'h0;
		end else begin
			tck_sync_reg <= {tck_sync_reg[1:0], tck_i};
			tms_sync_reg <= {tms_sync_reg[0], tms_i};
			tdi_sync_reg <= {tdi_sync_reg[0], tdi_i};
		end
	end

	assign tck_rise = tck_sync_reg[1] && !tck_sync_reg[2];
	assign tck_fall = !tck_sync_reg[1] && tck_sync_reg[2];
	assign tms_s    = tms_sync_reg[1];
	assign tdi_s    = tdi_sync_reg[1];

	// Standard controller walk
	function automatic dbg_pkg::tap_e tap_step(input dbg_pkg::tap_e s, input logic m);
		unique case (s)
			dbg_pkg::TAP_RESET:    tap_step = m ? dbg_pkg::TAP_RESET    : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_IDLE:     tap_step = m ? dbg_pkg::TAP_SEL_DR   : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_SEL_DR:   tap_step = m ? dbg_pkg::TAP_SEL_IR   : dbg_pkg::TAP_CAP_DR;
			dbg_pkg::TAP_CAP_DR:   tap_step = m ? dbg_pkg::TAP_EXIT1_DR : dbg_pkg::TAP_SHIFT_DR;
			dbg_pkg::TAP_SHIFT_DR: tap_step = m ? dbg_pkg::TAP_EXIT1_DR : dbg_pkg::TAP_SHIFT_DR;
			dbg_pkg::TAP_EXIT1_DR: tap_step = m ? dbg_pkg::TAP_UPD_DR   : dbg_pkg::TAP_PAUSE_DR;
			dbg_pkg::TAP_PAUSE_DR: tap_step = m ? dbg_pkg::TAP_EXIT2_DR : dbg_pkg::TAP_PAUSE_DR;
			dbg_pkg::TAP_EXIT2_DR: tap_step = m ? dbg_pkg::TAP_UPD_DR   : dbg_pkg::TAP_SHIFT_DR;
			dbg_pkg::TAP_UPD_DR:   tap_step = m ? dbg_pkg::TAP_SEL_DR   : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_SEL_IR:   tap_step = m ? dbg_pkg::TAP_RESET    : dbg_pkg::TAP_CAP_IR;
			dbg_pkg::TAP_CAP_IR:   tap_step = m ? dbg_pkg::TAP_EXIT1_IR : dbg_pkg::TAP_SHIFT_IR;
			dbg_pkg::TAP_SHIFT_IR: tap_step = m ? dbg_pkg::TAP_EXIT1_IR : dbg_pkg::TAP_SHIFT_IR;
			dbg_pkg::TAP_EXIT1_IR: tap_step = m ? dbg_pkg::TAP_UPD_IR   : dbg_pkg::TAP_PAUSE_IR;
			dbg_pkg::TAP_PAUSE_IR: tap_step = m ? dbg_pkg::TAP_EXIT2_IR : dbg_pkg::TAP_PAUSE_IR;
			dbg_pkg::TAP_EXIT2_IR: tap_step = m ? dbg_pkg::TAP_UPD_IR   : dbg_pkg::TAP_SHIFT_IR;
			dbg_pkg::TAP_UPD_IR:   tap_step = m ? dbg_pkg::TAP_SEL_DR   : dbg_pkg::TAP_IDLE;
		endcase
	endfunction

	// Probe-side state
	dbg_pkg::tap_e             tap_reg, tap_next;
	logic [3:0]                ir_reg, ir_next, irs_reg, irs_next;
	logic [dbg_pkg::DR_W-1:0]  dr_reg, dr_next;
	logic                      tdo_reg, tdo_next, oe_n_reg, oe_n_next;
	logic                      upd;
	logic [1:0]                cmd;
	logic                      mon_reg, mon_next;
	logic [1:0]                cmp_en_reg, cmp_en_next, cmp_brk_reg, cmp_brk_next;
	logic [1:0]                cmp_dq_reg, cmp_dq_next;
	logic [31:0]               cmp_addr_reg [2], cmp_addr_next [2];
	logic [31:0]               cmp_data_reg [2], cmp_data_next [2];
	logic [dbg_pkg::CTRL_LEN-1:0] status;
	// Core and flash state
	dbg_pkg::core_e            core_reg, core_next;
	logic [1:0]                cause_reg, cause_next;
	logic                      exc_reg, exc_next;
	logic [31:0]               rx_reg, rx_next, tx_reg, tx_next;
	logic                      rxv_reg, rxv_next, txv_reg, txv_next;
	logic                      rd_req_reg, rd_req_next, refused_reg, refused_next;
	logic [31:0]               rd_addr_reg, rd_addr_next, rd_data_reg, rd_data_next;
	logic                      erase_reg, erase_next;
	logic                      lock_reg, lock_next, loaded_reg;
	logic [1:0]                hit;
	logic                      bp_any, wp_any;

	assign upd = tck_rise && (tap_reg == dbg_pkg::TAP_UPD_DR);
	// Short frames land at the top of the shift path, so fields sit above DR_W-CTRL_LEN
	assign cmd = (upd && ir_reg == dbg_pkg::IR_CTRL) ?
	             dr_reg[dbg_pkg::DR_W-dbg_pkg::CTRL_LEN+dbg_pkg::CTRL_CMD_LSB +: 2] :
	             dbg_pkg::CMD_NONE;
	assign status = {core_reg == dbg_pkg::CORE_HALT, core_reg == dbg_pkg::CORE_STEP, mon_reg,
	                 lock_reg, rxv_reg, txv_reg, cause_reg};

	// Controller, shift paths and configuration writes from the probe
	always_comb begin
		tap_next      = tap_reg;
		ir_next       = ir_reg;
		irs_next      = irs_reg;
		dr_next       = dr_reg;
		tdo_next      = tdo_reg;
		oe_n_next     = oe_n_reg;
		mon_next      = mon_reg;
		cmp_en_next   = cmp_en_reg;
		cmp_brk_next  = cmp_brk_reg;
		cmp_dq_next   = cmp_dq_reg;
		cmp_addr_next = cmp_addr_reg;
		cmp_data_next = cmp_data_reg;
		if (tck_rise) begin
			tap_next = tap_step(tap_reg, tms_s);
			unique case (tap_reg)
				dbg_pkg::TAP_RESET:    ir_next  = dbg_pkg::IR_BYPASS;
				dbg_pkg::TAP_CAP_IR:   irs_next = dbg_pkg::IR_CAPTURE;
				dbg_pkg::TAP_SHIFT_IR: irs_next = {tdi_s, irs_reg[3:1]};
				dbg_pkg::TAP_UPD_IR:   ir_next  = irs_reg;
				dbg_pkg::TAP_SHIFT_DR: dr_next  = {tdi_s, dr_reg[dbg_pkg::DR_W-1:1]};
				dbg_pkg::TAP_CAP_DR: begin
					unique case (ir_reg)
						dbg_pkg::IR_CTRL: begin
							dr_next = '0;
							dr_next[dbg_pkg::CTRL_LEN-1:0] = status;
						end
						dbg_pkg::IR_COMM: begin
							dr_next = '0;
							dr_next[32:0] = {txv_reg, tx_reg};
						end
						dbg_pkg::IR_FLASH: begin
							dr_next = '0;
							dr_next[32:0] = {refused_reg, rd_data_reg};
						end
						default:           dr_next = '0;
					endcase
				end
				default: ;
			endcase
		end
		// Captured bit goes out on the falling probe clock edge
		if (tck_fall) begin
			tdo_next  = (tap_reg == dbg_pkg::TAP_SHIFT_IR) ? irs_reg[0] : dr_reg[0];
			oe_n_next = !(tap_reg == dbg_pkg::TAP_SHIFT_IR || tap_reg == dbg_pkg::TAP_SHIFT_DR);
		end
		if (upd && ir_reg == dbg_pkg::IR_CTRL) begin
			mon_next = dr_reg[dbg_pkg::DR_W-dbg_pkg::CTRL_LEN+dbg_pkg::CTRL_MON_BIT];
		end
		// Unit select is the lowest field of the compare word
		if (upd && ir_reg == dbg_pkg::IR_CMP) begin
			for (int u = 0; u < dbg_pkg::N_CMP; u++) begin
				if (dr_reg[dbg_pkg::CMP_UNIT_BIT] == u[0]) begin
					cmp_en_next[u]   = dr_reg[dbg_pkg::CMP_EN_BIT];
					cmp_brk_next[u]  = dr_reg[dbg_pkg::CMP_KIND_BIT];
					cmp_dq_next[u]   = dr_reg[dbg_pkg::CMP_DQ_BIT];
					cmp_addr_next[u] = dr_reg[dbg_pkg::CMP_ADDR_LSB +: 32];
					cmp_data_next[u] = dr_reg[dbg_pkg::CMP_DATA_LSB +: 32];
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tap_reg      <= dbg_pkg::TAP_RESET;
			ir_reg       <= dbg_pkg::IR_BYPASS;
			irs_reg      <= dbg_pkg::IR_CAPTURE;
			dr_reg       <= '0;
			tdo_reg      <= 1'b0;
			oe_n_reg     <= 1'b1;
			mon_reg      <= dbg_pkg::MON_RST;
			cmp_en_reg   <= 2'h0;
			cmp_brk_reg  <= 2'h0;
			cmp_dq_reg   <= 2'h0;
			cmp_addr_reg <= '{dbg_pkg::WORD_RST, dbg_pkg::WORD_RST};
			cmp_data_reg <= '{dbg_pkg::WORD_RST, dbg_pkg::WORD_RST};
		end else begin
			tap_reg      <= tap_next;
			ir_reg       <= ir_next;
			irs_reg      <= irs_next;
			dr_reg       <= dr_next;
			tdo_reg      <= tdo_next;
			oe_n_reg     <= oe_n_next;
			mon_reg      <= mon_next;
			cmp_en_reg   <= cmp_en_next;
			cmp_brk_reg  <= cmp_brk_next;
			cmp_dq_reg   <= cmp_dq_next;
			cmp_addr_reg <= cmp_addr_next;
			cmp_data_reg <= cmp_data_next;
		end
	end

	// Two compare units
	for (genvar g = 0; g < dbg_pkg::N_CMP; g++) begin : g_cmp
		dbg_compare u_cmp (
			.en_i         (cmp_en_reg[g]),
			.is_break_i   (cmp_brk_reg[g]),
			.data_qual_i  (cmp_dq_reg[g]),
			.cmp_addr_i   (cmp_addr_reg[g]),
			.cmp_data_i   (cmp_data_reg[g]),
			.fetch_valid_i(fetch_valid_i),
			.fetch_addr_i (fetch_addr_i),
			.fetch_instr_i(fetch_instr_i),
			.data_valid_i (data_valid_i),
			.data_addr_i  (data_addr_i),
			.data_value_i (data_value_i),
			.hit_o        (hit[g])
		);
	end
	assign bp_any = |(hit & cmp_brk_reg);
	assign wp_any = |(hit & ~cmp_brk_reg);

	// Core control, data channel, flash reads and lock
	always_comb begin
		core_next    = core_reg;
		cause_next   = cause_reg;
		exc_next     = 1'b0;
		rx_next      = rx_reg;
		tx_next      = tx_reg;
		rxv_next     = rxv_reg;
		txv_next     = txv_reg;
		rd_req_next  = rd_req_reg;
		rd_addr_next = rd_addr_reg;
		rd_data_next = rd_data_reg;
		refused_next = refused_reg;
		erase_next   = erase_reg;
		lock_next    = lock_reg;
		unique case (core_reg)
			dbg_pkg::CORE_RUN: begin
				if (cmd == dbg_pkg::CMD_HALT) begin
					core_next  = dbg_pkg::CORE_HALT;
					cause_next = dbg_pkg::CAUSE_REQ;
				end else if ((bp_any || wp_any) && mon_reg) begin
					exc_next = 1'b1;
				end else if (bp_any || wp_any) begin
					core_next  = dbg_pkg::CORE_HALT;
					cause_next = bp_any ? dbg_pkg::CAUSE_BREAK : dbg_pkg::CAUSE_WATCH;
				end
			end
			dbg_pkg::CORE_HALT: begin
				if (cmd == dbg_pkg::CMD_RUN) begin
					core_next  = dbg_pkg::CORE_RUN;
					cause_next = dbg_pkg::CAUSE_NONE;
				end else if (cmd == dbg_pkg::CMD_STEP) begin
					core_next = dbg_pkg::CORE_STEP;
				end
			end
			dbg_pkg::CORE_STEP: begin
				if (instr_retire_i) begin
					core_next = dbg_pkg::CORE_HALT;
				end
			end
			default: core_next = dbg_pkg::CORE_HALT;
		endcase
		// Channel flags: a new probe word beats an rx ack in the same cycle; tx takes a word only when empty
		if (comm_rx_ack_i) begin
			rxv_next = 1'b0;
		end
		if (upd && ir_reg == dbg_pkg::IR_COMM && dr_reg[dbg_pkg::DR_W-1]) begin
			rx_next  = dr_reg[dbg_pkg::DR_W-2 -: 32];
			rxv_next = 1'b1;
		end
		if (tck_rise && tap_reg == dbg_pkg::TAP_CAP_DR && ir_reg == dbg_pkg::IR_COMM) begin
			txv_next = 1'b0;
		end
		if (comm_tx_valid_i && !txv_reg) begin
			tx_next  = comm_tx_data_i;
			txv_next = 1'b1;
		end
		// Readout; a lock refuses before any request reaches flash
		if (flash_rd_done_i && rd_req_reg) begin
			rd_req_next  = 1'b0;
			rd_data_next = flash_rd_data_i;
		end
		if (upd && ir_reg == dbg_pkg::IR_FLASH && !rd_req_reg) begin
			refused_next = lock_reg;
			rd_req_next  = !lock_reg;
			rd_addr_next = dr_reg[dbg_pkg::DR_W-2 -: 32];
			if (lock_reg) begin
				rd_data_next = dbg_pkg::WORD_RST;
			end
		end
		// Whole erase is the only path that lowers the lock
		if (upd && ir_reg == dbg_pkg::IR_ERASE && dr_reg[dbg_pkg::DR_W-1]) begin
			erase_next = 1'b1;
		end
		if (!loaded_reg) begin
			lock_next = lock_nv_i;
		end else if (erase_reg && flash_erase_done_i) begin
			erase_next = 1'b0;
			lock_next  = 1'b0;
		end else if (lock_program_i) begin
			lock_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_reg    <= dbg_pkg::CORE_RUN;
			cause_reg   <= dbg_pkg::CAUSE_NONE;
			exc_reg     <= 1'b0;
			rx_reg      <= dbg_pkg::WORD_RST;
			tx_reg      <= dbg_pkg::WORD_RST;
			rxv_reg     <= 1'b0;
			txv_reg     <= 1'b0;
			rd_req_reg  <= 1'b0;
			rd_addr_reg <= dbg_pkg::WORD_RST;
			rd_data_reg <= dbg_pkg::WORD_RST;
			refused_reg <= 1'b0;
			erase_reg   <= 1'b0;
			lock_reg    <= 1'b1; // Safe until the stored bit is loaded
			loaded_reg  <= 1'b0;
		end else begin
			core_reg    <= core_next;
			cause_reg   <= cause_next;
			exc_reg     <= exc_next;
			rx_reg      <= rx_next;
			tx_reg      <= tx_next;
			rxv_reg     <= rxv_next;
			txv_reg     <= txv_next;
			rd_req_reg  <= rd_req_next;
			rd_addr_reg <= rd_addr_next;
			rd_data_reg <= rd_data_next;
			refused_reg <= refused_next;
			erase_reg   <= erase_next;
			lock_reg    <= lock_next;
			loaded_reg  <= 1'b1;
		end
	end

	// Outputs; halt and isolation share one state
	assign tdo_o             = tdo_reg;
	assign tdo_oe_n_o        = oe_n_reg;
	assign core_halt_o       = (core_reg == dbg_pkg::CORE_HALT);
	assign core_isolate_o    = (core_reg == dbg_pkg::CORE_HALT);
	assign debug_exc_o       = exc_reg;
	assign comm_rx_data_o    = rx_reg;
	assign comm_rx_valid_o   = rxv_reg;
	assign comm_tx_full_o    = txv_reg;
	assign flash_rd_req_o    = rd_req_reg;
	assign flash_rd_addr_o   = rd_addr_reg;
	assign flash_erase_req_o = erase_reg;
	assign cpu_lock_o        = lock_reg;

	sequence s_step_go;
		core_reg == dbg_pkg::CORE_HALT && cmd == dbg_pkg::CMD_STEP ##1 !core_halt_o;
	endsequence
	sequence s_retire;
		core_reg == dbg_pkg::CORE_STEP && instr_retire_i;
	endsequence

	property p_hit_halts;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		core_reg == dbg_pkg::CORE_RUN && !mon_reg && (bp_any || wp_any) |=> core_halt_o;
	endproperty
	a_hit_halts: assert property (p_hit_halts) else $error("hit did not halt");
	property p_isolated;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		core_halt_o |-> core_isolate_o && !debug_exc_o;
	endproperty
	a_isolated: assert property (p_isolated) else $error("halted core not isolated");
	property p_run_cmd;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		core_halt_o && cmd == dbg_pkg::CMD_RUN |=> !core_halt_o && cause_reg == dbg_pkg::CAUSE_NONE;
	endproperty
	a_run_cmd: assert property (p_run_cmd) else $error("run command ignored");
	property p_step;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_step_go |-> core_reg == dbg_pkg::CORE_STEP;
	endproperty
	a_step: assert property (p_step) else $error("step did not start");
	property p_step_end;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_retire |=> core_halt_o ##1 (core_halt_o || cmd != dbg_pkg::CMD_NONE || $past(cmd) != 2'h0);
	endproperty
	a_step_end: assert property (p_step_end) else $error("step did not stop after one");
	property p_monitor;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		core_reg == dbg_pkg::CORE_RUN && mon_reg && (bp_any || wp_any) && cmd == dbg_pkg::CMD_NONE
		|=> debug_exc_o && !core_halt_o;
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor hit not an exception");
	property p_comm;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		upd && ir_reg == dbg_pkg::IR_COMM && dr_reg[dbg_pkg::DR_W-1] && !core_halt_o
		&& cmd == dbg_pkg::CMD_NONE && !(bp_any || wp_any)
		|=> comm_rx_valid_o && comm_rx_data_o == $past(dr_reg[66:35]) && !core_halt_o;
	endproperty
	a_comm: assert property (p_comm) else $error("channel word lost or core stopped");
	property p_refuse;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		lock_reg && !rd_req_reg |=> !flash_rd_req_o;
	endproperty
	a_refuse: assert property (p_refuse) else $error("locked read reached flash");
	property p_clear;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		loaded_reg && $past(loaded_reg) && $fell(lock_reg) |-> $past(erase_reg && flash_erase_done_i);
	endproperty
	a_clear: assert property (p_clear) else $error("lock cleared without erase");
	property p_lock_view;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		loaded_reg && !lock_program_i && !flash_erase_done_i |=> $stable(cpu_lock_o);
	endproperty
	a_lock_view: assert property (p_lock_view) else $error("lock changed by other path");
endmodule

// File: core/dbg_pkg.sv
// Constants, instruction codes and state types for the debug port.
// Assumes one system clock; all probe pins are sampled on it.
package dbg_pkg;
	// Instruction register
	localparam int         IR_W          = 4;
	localparam logic [3:0] IR_CAPTURE    = 4'h1;
	localparam logic [3:0] IR_BYPASS     = 4'hF;
	localparam logic [3:0] IR_CTRL       = 4'h1;
	localparam logic [3:0] IR_CMP        = 4'h2;
	localparam logic [3:0] IR_COMM       = 4'h3;
	localparam logic [3:0] IR_FLASH      = 4'h4;
	localparam logic [3:0] IR_ERASE      = 4'h5;
	// Data register lengths, shifted LSB first
	localparam int         DR_W          = 68;
	localparam int         CTRL_LEN      = 8;
	localparam int         COMM_LEN      = 33;
	localparam int         FLASH_LEN     = 33;
	// Control register fields
	localparam int         CTRL_CMD_LSB  = 0;
	localparam int         CTRL_MON_BIT  = 2;
	localparam logic [1:0] CMD_NONE      = 2'h0;
	localparam logic [1:0] CMD_HALT      = 2'h1;
	localparam logic [1:0] CMD_RUN       = 2'h2;
	localparam logic [1:0] CMD_STEP      = 2'h3;
	// Compare unit fields
	localparam int         N_CMP         = 2;
	localparam int         CMP_UNIT_BIT  = 0;
	localparam int         CMP_EN_BIT    = 1;
	localparam int         CMP_KIND_BIT  = 2;
	localparam int         CMP_DQ_BIT    = 3;
	localparam int         CMP_ADDR_LSB  = 4;
	localparam int         CMP_DATA_LSB  = 36;
	// Halt causes
	localparam logic [1:0] CAUSE_NONE    = 2'h0;
	localparam logic [1:0] CAUSE_BREAK   = 2'h1;
	localparam logic [1:0] CAUSE_WATCH   = 2'h2;
	localparam logic [1:0] CAUSE_REQ     = 2'h3;
	// Reset values
	localparam logic       MON_RST       = 1'b0;
	localparam logic [31:0] WORD_RST     = 32'h0000_0000;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} tap_e;

	typedef enum logic [1:0] {
		CORE_RUN, CORE_HALT, CORE_STEP
	} core_e;
endpackage

// File: core/dbg_compare.sv
// One address/data compare unit, watchpoint or breakpoint.
// Assumes fetch and data buses are on the system clock and valid for one cycle.
`timescale 1ns/1ps
module dbg_compare (
	input  wire logic        en_i,
	input  wire logic        is_break_i,
	input  wire logic        data_qual_i,
	input  wire logic [31:0] cmp_addr_i,
	input  wire logic [31:0] cmp_data_i,
	input  wire logic        fetch_valid_i,
	input  wire logic [31:0] fetch_addr_i,
	input  wire logic [31:0] fetch_instr_i,
	input  wire logic        data_valid_i,
	input  wire logic [31:0] data_addr_i,
	input  wire logic [31:0] data_value_i,
	output logic             hit_o
);
	logic bp_hit;
	logic wp_hit;

	// Breakpoint on fetch, optionally qualified by the fetched word
	assign bp_hit = fetch_valid_i && (fetch_addr_i == cmp_addr_i) &&
	                (!data_qual_i || (fetch_instr_i == cmp_data_i));
	// Watchpoint on data access address
	assign wp_hit = data_valid_i && (data_addr_i == cmp_addr_i);
	// Kind selects which half counts
	assign hit_o  = en_i && (is_break_i ? bp_hit : wp_hit);
endmodule

// File: dv/probe_model.sv
// Debug probe stand-in: drives tck, tms and tdi and reads tdo.
// Assumes the port samples tck on its own clock; tck stands still between frames.
`timescale 1ns/1ps
module probe_model (
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i,
	input  wire logic tdo_oe_n_i
);
	int half = 100; // Half period in ns; raised to act as a slow probe

	// Pins idle with the tap held in reset
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// One tck period; tdo taken at the rise, a released tdo reads inverted
	task automatic bit_(input logic ms, input logic di, output logic dq);
		tms_o = ms;
		tdi_o = di;
		#(half) tck_o = 1'b1;
		dq = tdo_oe_n_i ? ~tdo_i : tdo_i;
		#(half) tck_o = 1'b0;
	endtask

	// Five ones reach reset whatever the state, then park in idle
	task automatic tap_reset();
		logic x;
		for (int i = 0; i < 6; i++) bit_(i < 5, ~tdi_o, x);
	endtask

	// Frame from idle: capture, shift n bits LSB first, update, idle
	task automatic scan(input logic ir, input logic [67:0] d, input int n,
			output logic [67:0] q);
		logic x;
		q = '0;
		bit_(1'b1, ~tdi_o, x);
		if (ir) bit_(1'b1, ~tdi_o, x);
		bit_(1'b0, ~tdi_o, x);
		bit_(1'b0, ~tdi_o, x);
		for (int i = 0; i < n; i++) begin
			bit_(i == n - 1, d[i], x);
			q[i] = x;
		end
		bit_(1'b1, ~tdi_o, x);
		bit_(1'b0, ~tdi_o, x);
		tdi_o = ~tdi_o; // No stale level left on the line
	endtask
endmodule

// File: dv/cpu_debug_and_flash_lock_bench.sv
// Bench for the debug port: probe model on the pins, model state in integers.
// Assumes dbg_pkg and dbg_port are compiled first.
`timescale 1ns/1ps
module cpu_debug_and_flash_lock_bench;
	logic        sys_clk_i, rst_n_i, tck, tms, tdi, tdo_o, tdo_oe_n_o, instr_retire_i;
	logic        fetch_valid_i, data_valid_i, comm_rx_ack_i, comm_tx_valid_i;
	logic [31:0] fetch_addr_i, fetch_instr_i, data_addr_i, data_value_i, comm_tx_data_i;
	logic        core_halt_o, core_isolate_o, debug_exc_o, comm_rx_valid_o, comm_tx_full_o;
	logic [31:0] comm_rx_data_o, flash_rd_addr_o, flash_rd_data_i, a, w;
	logic        flash_rd_req_o, flash_rd_done_i, flash_erase_req_o, flash_erase_done_i;
	logic        lock_nv_i, lock_program_i, cpu_lock_o;
	logic [67:0] q;
	int          err_count = 0, n_compared = 0, n_rd = 0, n_er = 0, m_halt, m_lock, m_mon;

	dbg_port dbg_port_inst (.sys_clk_i, .rst_n_i, .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o, .tdo_oe_n_o, .fetch_valid_i, .fetch_addr_i, .fetch_instr_i, .data_valid_i,
		.data_addr_i, .data_value_i, .instr_retire_i, .core_halt_o, .core_isolate_o,
		.debug_exc_o, .comm_rx_data_o, .comm_rx_valid_o, .comm_rx_ack_i, .comm_tx_valid_i,
		.comm_tx_data_i, .comm_tx_full_o, .flash_rd_req_o, .flash_rd_addr_o,
		.flash_rd_done_i, .flash_rd_data_i, .flash_erase_req_o, .flash_erase_done_i,
		.lock_nv_i, .lock_program_i, .cpu_lock_o);
	probe_model probe_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o),
		.tdo_oe_n_i(tdo_oe_n_o));

	// 40 MHz system clock
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	// Flash stand-in: answers each request at the next falling edge
	always @(negedge sys_clk_i) begin
		flash_rd_done_i <= flash_rd_req_o & ~flash_rd_done_i;
		flash_rd_data_i <= ~flash_rd_addr_o;
		flash_erase_done_i <= flash_erase_req_o & ~flash_erase_done_i;
		n_rd <= n_rd + 32'(flash_rd_req_o & ~flash_rd_done_i);
		n_er <= n_er + 32'(flash_erase_req_o & ~flash_erase_done_i);
	end

	task automatic chk(input string s, input logic [67:0] e, input logic [67:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	// Load an instruction, then one data frame; action lands within 3 clocks
	task automatic dr(input logic [3:0] ir, input logic [67:0] d, input int n);
		probe_model_inst.scan(1'b1, 68'(ir), dbg_pkg::IR_W, q);
		probe_model_inst.scan(1'b0, d, n, q);
		cyc(3);
	endtask
	task automatic ctrl(input logic [1:0] c);
		dr(dbg_pkg::IR_CTRL, 68'({m_mon[0], c}), dbg_pkg::CTRL_LEN);
	endtask
	// Compare pins and captured status with the model; cause only when halted
	task automatic look(input string s, input int cause);
		ctrl(dbg_pkg::CMD_NONE);
		chk({s, " halt"}, m_halt, core_halt_o);
		chk({s, " isolate"}, m_halt, core_isolate_o);
		chk({s, " lock"}, m_lock, cpu_lock_o);
		chk({s, " status"}, {m_halt[0], m_mon[0], m_lock[0]}, {q[7], q[5], q[4]});
		if (cause >= 0) chk({s, " cause"}, cause, q[1:0]);
		$display("test %s done", s);
	endtask
	task automatic fetch(input logic [31:0] fa, input logic [31:0] fw);
		fetch_addr_i = fa;
		fetch_instr_i = fw;
		fetch_valid_i = 1'b1;
		cyc(1);
		fetch_valid_i = 1'b0;
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 205 us
	initial begin
		#1ms;
		err_count++;
		end_sim();
	end

	initial begin
		{rst_n_i, fetch_valid_i, data_valid_i, instr_retire_i, comm_rx_ack_i} = '0;
		{comm_tx_valid_i, lock_program_i} = '0;
		{fetch_addr_i, fetch_instr_i, data_addr_i, data_value_i, comm_tx_data_i} = '0;
		lock_nv_i = 1'b1;
		void'($urandom(32'hc25c));
		{m_halt, m_lock, m_mon} = {32'd0, 32'd1, 32'd0};
		cyc(4);
		rst_n_i = 1'b1;
		cyc(3);
		probe_model_inst.tap_reset();
		look("reset", -1);
		dr(dbg_pkg::IR_FLASH, 68'h0000_0100, dbg_pkg::FLASH_LEN);
		dr(dbg_pkg::IR_FLASH, 68'h0000_0100, dbg_pkg::FLASH_LEN);
		chk("refused", 33'h1_0000_0000, q[32:0]);
		chk("reads", 0, n_rd);
		dr(dbg_pkg::IR_ERASE, 68'h1, 1);
		m_lock = 0;
		chk("erases", 1, n_er);
		look("erase", -1);
		a = $urandom & 32'hffff_fffc;
		dr(dbg_pkg::IR_FLASH, 68'(a), dbg_pkg::FLASH_LEN);
		dr(dbg_pkg::IR_FLASH, 68'(a), dbg_pkg::FLASH_LEN);
		chk("flash data", {1'b0, ~a}, q[32:0]);
		lock_program_i = 1'b1;
		cyc(1);
		lock_program_i = 1'b0;
		cyc(2);
		m_lock = 1;
		look("relock", -1);
		dr(dbg_pkg::IR_CMP, {32'h0, a, 4'b0110}, dbg_pkg::DR_W);
		fetch(a + 32'h4, 32'h0);
		chk("other fetch", 0, core_halt_o);
		fetch(a, 32'h0);
		m_halt = 1;
		look("break", 1);
		ctrl(dbg_pkg::CMD_STEP);
		fetch(a, 32'h0);
		chk("stepping", 0, core_halt_o);
		instr_retire_i = 1'b1;
		cyc(1);
		instr_retire_i = 1'b0;
		cyc(1);
		look("step", -1);
		ctrl(dbg_pkg::CMD_RUN);
		m_halt = 0;
		look("run", -1);
		data_addr_i = a ^ 32'h0000_0100;
		dr(dbg_pkg::IR_CMP, {32'h0, data_addr_i, 4'b0011}, dbg_pkg::DR_W);
		data_valid_i = 1'b1;
		cyc(1);
		data_valid_i = 1'b0;
		m_halt = 1;
		look("watch", 2);
		ctrl(dbg_pkg::CMD_RUN);
		ctrl(dbg_pkg::CMD_HALT);
		look("request", 3);
		ctrl(dbg_pkg::CMD_RUN);
		m_halt = 0;
		w = $urandom;
		dr(dbg_pkg::IR_CMP, {w, a, 4'b1110}, dbg_pkg::DR_W);
		fetch(a, ~w);
		chk("qualify miss", 0, core_halt_o);
		fetch(a, w);
		m_halt = 1;
		look("qualify", 1);
		ctrl(dbg_pkg::CMD_RUN);
		m_halt = 0;
		m_mon = 1;
		ctrl(dbg_pkg::CMD_NONE);
		fetch(a, w);
		chk("exception", 1, debug_exc_o);
		cyc(1);
		chk("exception end", 0, debug_exc_o);
		probe_model_inst.half = 150;
		dr(dbg_pkg::IR_COMM, 68'({1'b1, w}), dbg_pkg::COMM_LEN);
		chk("rx", {1'b1, w}, {comm_rx_valid_o, comm_rx_data_o});
		comm_rx_ack_i = 1'b1;
		comm_tx_data_i = ~w;
		comm_tx_valid_i = 1'b1;
		cyc(1);
		{comm_rx_ack_i, comm_tx_valid_i} = 2'b00;
		cyc(1);
		chk("rx ack tx full", 2'b01, {comm_rx_valid_o, comm_tx_full_o});
		dr(dbg_pkg::IR_COMM, 68'h0, dbg_pkg::COMM_LEN);
		chk("tx", {1'b1, ~w}, q[32:0]);
		chk("tx drained", 0, comm_tx_full_o);
		look("monitor", -1);
		end_sim();
	end
endmodule
